// *** inc/rcpf_pkg.sv ***
/*
  Constants, command codes, field layout and state type for the image RAM
  command block. Assumes 8-bit serial bytes and a 400 x 300 one-bit plane.
*/
package rcpf_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_FILL_BW  = 8'h47;
  localparam logic [7:0] CMD_SET_X    = 8'h4E;
  localparam logic [7:0] CMD_SET_Y    = 8'h4F;
  localparam logic [7:0] CMD_NOP      = 8'h7F;
  localparam logic [7:0] CMD_WRITE_BW = 8'h24;

  // ----------------------------------------------------------------
  // Plane geometry, one byte holds eight source columns
  // ----------------------------------------------------------------
  localparam int          RAM_DEPTH = 15000;
  localparam int          ADDR_W    = 14;
  localparam logic [13:0] COLS_W    = 14'h0032;
  localparam logic [5:0]  COL_LAST  = 6'h31;
  localparam logic [8:0]  ROW_LAST  = 9'h12B;

  // ----------------------------------------------------------------
  // Fill setting fields and reset values
  // ----------------------------------------------------------------
  localparam int         FILL_FIRST_BIT = 7;
  localparam int         FILL_H_LSB     = 4;
  localparam int         FILL_W_LSB     = 0;
  localparam logic [2:0] STEP_FULL      = 3'h6;
  localparam logic [3:0] ROW_STEP_BASE  = 4'h3;
  localparam logic [7:0] FILL_RST       = 8'h00;
  localparam logic [5:0] X_RST          = 6'h00;
  localparam logic [8:0] Y_RST          = 9'h000;
  localparam logic [2:0] BIT_LAST       = 3'h7;

  typedef enum logic [2:0] {
    ST_CMD, ST_FILL_P, ST_X_P, ST_Y_P0, ST_Y_P1, ST_WRITE, ST_SKIP, ST_FILL
  } rcpf_state_e;
endpackage

// *** inc/rcpf_ram_if.sv ***
/*
  Write and scan-read port of the black/white image plane.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface rcpf_ram_if;
  logic        we;
  logic [13:0] waddr;
  logic [7:0]  wdata;
  logic [13:0] raddr;
  logic [7:0]  rdata;
  modport ctl (output we, output waddr, output wdata, output raddr,
               input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
endinterface

// *** rtl/rcpf_bw_ram.sv ***
/*
  Black/white image plane storage, one write port and one registered read.
  Assumes addresses below the plane depth.
*/
`timescale 1ns/1ns
module rcpf_bw_ram
  import rcpf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  rcpf_ram_if.mem  port
);
  logic [7:0] mem_q [0:RAM_DEPTH-1];

  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port.rdata <= 8'h00;
    end else begin
      port.rdata <= mem_q[port.raddr];
    end
  end
endmodule

// *** rtl/rcpf_top.sv ***
/*
  Serial command interpreter for the image RAM: pattern fill of the
  black/white plane, RAM address counter loads, no-operation and the
  plane write stream. Assumes a mode-0 serial host, MSB first, and
  bytes spaced so that each crosses into ref_clk before the next ends.
*/
// Notes on behaviour
// - Command 47h plus one parameter fills the whole b/w plane in blocks.
// - Setting bit 7 is the value of the first block; blocks alternate.
// - Setting bits 6..4 pick block height 8..256 rows or 300 rows.
// - Setting bits 2..0 pick block width 8..256 columns or 400 columns.
// - Busy is high for the whole fill and low once it completes.
// - Command 4Eh loads the 6-bit X counter from its parameter; reset 0.
// - Command 4Fh loads the 9-bit Y counter from two bytes, low first.
// - Command 7Fh changes no counter or fill setting.
// - Command 7Fh ends a running RAM write stream.
// - The filled plane is the one written by command 24h.
`timescale 1ns/1ns
module rcpf_top
  import rcpf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sdi,
  input  wire logic        spi_dc,
  output logic             busy,
  output logic [5:0]       ram_addr_counter_x,
  output logic [8:0]       ram_addr_counter_y,
  input  wire logic [13:0] scan_addr,
  output logic [7:0]       scan_data
);
  // ----------------------------------------------------------------
  // Link domain: byte assembly
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [6:0] shf_q, shf_d;
  logic [7:0] hold_byte_q, hold_byte_d;
  logic       hold_dc_q, hold_dc_d;
  logic       tgl_q, tgl_d;
  logic       byte_done;

  always_comb begin
    byte_done   = (bit_cnt_q == BIT_LAST);
    bit_cnt_d   = bit_cnt_q + 3'h1;
    shf_d       = {shf_q[5:0], spi_sdi};
    hold_byte_d = byte_done ? {shf_q, spi_sdi} : hold_byte_q;
    hold_dc_d   = byte_done ? spi_dc : hold_dc_q;
    tgl_d       = byte_done ? ~tgl_q : tgl_q;
  end

  // Frame boundary resets the bit count while the clock stands still
  always_ff @(posedge spi_sclk or posedge spi_cs_n or posedge sys_rst) begin
    if (sys_rst || spi_cs_n) begin
      bit_cnt_q <= 3'h0;
      shf_q     <= 7'h00;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shf_q     <= shf_d;
    end
  end

  // Not cleared by chip select, so a toggle is never lost at frame end
  always_ff @(posedge spi_sclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_byte_q <= 8'h00;
      hold_dc_q   <= 1'b0;
      tgl_q       <= 1'b0;
    end else begin
      hold_byte_q <= hold_byte_d;
      hold_dc_q   <= hold_dc_d;
      tgl_q       <= tgl_d;
    end
  end

  // ----------------------------------------------------------------
  // Crossing: toggle synchroniser, held byte read once stable
  // ----------------------------------------------------------------
  logic       sync1_q, sync2_q, seen_q;
  logic       evt_q, evt_d;
  logic [7:0] byte_q, byte_d;
  logic       dc_q, dc_d;

  always_comb begin
    evt_d  = sync2_q ^ seen_q;
    byte_d = evt_d ? hold_byte_q : byte_q;
    dc_d   = evt_d ? hold_dc_q : dc_q;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      seen_q  <= 1'b0;
      evt_q   <= 1'b0;
      byte_q  <= 8'h00;
      dc_q    <= 1'b0;
    end else begin
      sync1_q <= tgl_q;
      sync2_q <= sync1_q;
      seen_q  <= sync2_q;
      evt_q   <= evt_d;
      byte_q  <= byte_d;
      dc_q    <= dc_d;
    end
  end

  // ----------------------------------------------------------------
  // Command decode, counters and fill walk
  // ----------------------------------------------------------------
  rcpf_state_e st_q, st_d;
  logic [7:0]  fill_set_q, fill_set_d;
  logic [5:0]  x_q, x_d, fcol_q, fcol_d;
  logic [8:0]  y_q, y_d, frow_q, frow_d;
  logic [7:0]  ylow_q, ylow_d;
  logic [2:0]  h_code, w_code;
  logic        row_par, col_par;
  logic [7:0]  fill_byte;
  logic [13:0] fill_addr, strm_addr;

  rcpf_ram_if ram_if ();

  always_comb begin
    h_code    = fill_set_q[FILL_H_LSB +: 3];
    w_code    = fill_set_q[FILL_W_LSB +: 3];
    // Full-size steps and the illegal code give no alternation along their own axis
    row_par   = (h_code < STEP_FULL) ?
                frow_q[{1'b0, h_code} + ROW_STEP_BASE] : 1'b0;
    col_par   = (w_code < STEP_FULL) ? fcol_q[w_code] : 1'b0;
    fill_byte = {8{fill_set_q[FILL_FIRST_BIT] ^ row_par ^ col_par}};
    fill_addr = {5'h00, frow_q} * COLS_W + {8'h00, fcol_q};
    strm_addr = {5'h00, y_q} * COLS_W + {8'h00, x_q};
  end

  always_comb begin
    st_d          = st_q;
    fill_set_d    = fill_set_q;
    x_d           = x_q;
    y_d           = y_q;
    ylow_d        = ylow_q;
    fcol_d        = fcol_q;
    frow_d        = frow_q;
    ram_if.we     = 1'b0;
    ram_if.waddr  = strm_addr;
    ram_if.wdata  = byte_q;
    ram_if.raddr  = scan_addr;
    if (st_q == ST_FILL) begin
      // Same plane as the stream write port
      ram_if.we    = 1'b1;
      ram_if.waddr = fill_addr;
      ram_if.wdata = fill_byte;
      if (fcol_q == COL_LAST) begin
        fcol_d = 6'h00;
        frow_d = frow_q + 9'h001;
        if (frow_q == ROW_LAST) begin
          st_d = ST_CMD;
        end
      end else begin
        fcol_d = fcol_q + 6'h01;
      end
    end else if (evt_q && !dc_q) begin
      case (byte_q)
        CMD_FILL_BW:  st_d = ST_FILL_P;
        CMD_SET_X:    st_d = ST_X_P;
        CMD_SET_Y:    st_d = ST_Y_P0;
        CMD_WRITE_BW: st_d = ST_WRITE;
        CMD_NOP:      st_d = ST_CMD;
        default:      st_d = ST_SKIP;
      endcase
    end else if (evt_q) begin
      unique case (st_q)
        ST_FILL_P: begin
          fill_set_d = byte_q;
          fcol_d     = 6'h00;
          frow_d     = 9'h000;
          st_d       = ST_FILL;
        end
        ST_X_P: begin
          x_d  = byte_q[5:0];
          st_d = ST_SKIP;
        end
        ST_Y_P0: begin
          ylow_d = byte_q;
          st_d   = ST_Y_P1;
        end
        ST_Y_P1: begin
          y_d  = {byte_q[0], ylow_q};
          st_d = ST_SKIP;
        end
        ST_WRITE: begin
          ram_if.we = 1'b1;
          if (x_q == COL_LAST) begin
            x_d = 6'h00;
            y_d = (y_q == ROW_LAST) ? 9'h000 : y_q + 9'h001;
          end else begin
            x_d = x_q + 6'h01;
          end
        end
        ST_CMD, ST_SKIP, ST_FILL: begin
          st_d = st_q;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q       <= ST_CMD;
      fill_set_q <= FILL_RST;
      x_q        <= X_RST;
      y_q        <= Y_RST;
      ylow_q     <= 8'h00;
      fcol_q     <= 6'h00;
      frow_q     <= 9'h000;
    end else begin
      st_q       <= st_d;
      fill_set_q <= fill_set_d;
      x_q        <= x_d;
      y_q        <= y_d;
      ylow_q     <= ylow_d;
      fcol_q     <= fcol_d;
      frow_q     <= frow_d;
    end
  end

  // Bytes arriving during a fill are dropped, not queued
  assign busy               = (st_q == ST_FILL);
  assign ram_addr_counter_x = x_q;
  assign ram_addr_counter_y = y_q;
  assign scan_data          = ram_if.rdata;

  rcpf_bw_ram u_ram (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .port    (ram_if.mem)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic par_evt, cmd_evt;
  assign par_evt = evt_q && dc_q && !busy;
  assign cmd_evt = evt_q && !dc_q && !busy;

  chk_busy_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
    par_evt && st_q == ST_FILL_P |=> busy [*8])
    else $error("busy not raised for fill");
  chk_busy_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(busy) |-> $past(frow_q) == ROW_LAST && $past(fcol_q) == COL_LAST)
    else $error("busy dropped before last byte");
  chk_fill_setting: assert property (@(posedge ref_clk) disable iff (sys_rst)
    par_evt && st_q == ST_FILL_P |=> fill_set_q == $past(byte_q))
    else $error("fill setting not taken");
  chk_fill_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
    busy && frow_q == 9'h000 && fcol_q == 6'h00 |->
      ram_if.we && ram_if.wdata == {8{fill_set_q[7]}} &&
      ram_if.waddr == 14'h0000)
    else $error("first fill step wrong");
  chk_x_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    par_evt && st_q == ST_X_P |=> ram_addr_counter_x == $past(byte_q[5:0]))
    else $error("x counter load wrong");
  chk_y_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    par_evt && st_q == ST_Y_P1 |=>
      ram_addr_counter_y == {$past(byte_q[0]), $past(ylow_q)})
    else $error("y counter load wrong");
  chk_nop_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_evt && byte_q == CMD_NOP |=>
      $stable(x_q) && $stable(y_q) && $stable(fill_set_q))
    else $error("nop changed state");
  chk_nop_ends: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_evt && byte_q == CMD_NOP ##1 (!evt_q) [*2] |-> st_q == ST_CMD)
    else $error("nop did not end stream");
  chk_stream_wr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    par_evt && st_q == ST_WRITE |-> ram_if.we && ram_if.waddr == strm_addr
      && ram_if.wdata == byte_q)
    else $error("stream byte not written");
  chk_cmd_decode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_evt |=> (st_q == ST_WRITE) == ($past(byte_q) == CMD_WRITE_BW))
    else $error("command decode wrong");

  cov_fill_done: cover property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(busy));
  cov_nop_stream: cover property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_evt && byte_q == CMD_NOP && st_q == ST_WRITE);
  cov_y_load: cover property (@(posedge ref_clk) disable iff (sys_rst)
    par_evt && st_q == ST_Y_P1 && byte_q[0]);
  cov_wrap: cover property (@(posedge ref_clk) disable iff (sys_rst)
    par_evt && st_q == ST_WRITE && x_q == COL_LAST);
endmodule

// *** tb/rcpf_host_model.sv ***
/*
  Host side of the serial command link: sends one byte per frame.
  Assumes mode 0, MSB first, and a 12 ns link clock.
*/
`timescale 1ns/1ns
module rcpf_host_model (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  output logic      spi_dc,
  input  wire logic busy
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
    spi_dc   = 1'b0;
  end

  // ----------------------------------------------------------------
  // Byte frame
  // ----------------------------------------------------------------
  // Gap first keeps byte completions at least 353 ns apart; clock idles low
  task automatic send_byte(input logic dc, input logic [7:0] b);
    int n;
    n = 0;
    #257;
    while (!dc && busy !== 1'b0 && n < 20000) begin
      #40;
      n++;
    end
    spi_dc   = dc;
    spi_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      spi_sdi = b[i];
      #6 spi_sclk = 1'b1;
      #6 spi_sclk = 1'b0;
    end
    spi_cs_n = 1'b1;
    // Released line shows the inverse, not a stale bit
    spi_sdi  = ~b[0];
    spi_dc   = ~dc;
  endtask
endmodule

// *** tb/testbench.sv ***
/*
  Self-checking bench for the image RAM command block.
  Assumes the host model as link driver and the scan port for readback.
*/
`timescale 1ns/1ns
module testbench
  import rcpf_pkg::*;
;
  logic        ref_clk;
  logic        sys_rst;
  logic        spi_sclk;
  logic        spi_cs_n;
  logic        spi_sdi;
  logic        spi_dc;
  logic        busy;
  logic [5:0]  ram_addr_counter_x;
  logic [8:0]  ram_addr_counter_y;
  logic [13:0] scan_addr;
  logic [7:0]  scan_data;
  int          miscompares;
  int          samples_checked;
  logic [7:0]  fills [6] = '{8'h06, 8'h10, 8'h25, 8'h31, 8'h64, 8'h52};

  rcpf_top dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_dc(spi_dc),
    .busy(busy), .ram_addr_counter_x(ram_addr_counter_x),
    .ram_addr_counter_y(ram_addr_counter_y), .scan_addr(scan_addr),
    .scan_data(scan_data)
  );

  rcpf_host_model host (
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_dc(spi_dc), .busy(busy)
  );

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] fill_byte(logic [7:0] a, int r, int c);
    int h;
    int w;
    h = (a[6:4] < 3'h6) ? (8 << a[6:4]) : 300;
    w = (a[2:0] < 3'h6) ? (8 << a[2:0]) : 400;
    return {8{a[7] ^ ((r / h) % 2 == 1) ^ (((c * 8) / w) % 2 == 1)}};
  endfunction

  task automatic settle();
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic read_at(input int a, output logic [7:0] d);
    @(posedge ref_clk);
    scan_addr <= a[13:0];
    @(posedge ref_clk);
    @(negedge ref_clk);
    d = scan_data;
  endtask

  task automatic run_fill(input logic [7:0] a);
    int         n;
    int         p;
    logic [7:0] d;
    n = 0;
    host.send_byte(1'b0, CMD_FILL_BW);
    host.send_byte(1'b1, a);
    while (busy !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    while (busy === 1'b1 && n < 16000) begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, n >= 14999 && n <= 15001}, 16'h0001);
    for (int j = 0; j < 12; j++) begin
      p = (j < 2) ? j * 14999 : $urandom_range(14999);
      read_at(p, d);
      check({8'h00, d}, {8'h00, fill_byte(a, p / 50, p % 50)});
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [7:0]  a;
    logic [7:0]  d;
    logic [7:0]  dat [3];
    sys_rst = 1'b0;
    scan_addr = 14'h0000;
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(75));
    // A real rising edge after time zero clears the link-side flops
    #1;
    sys_rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check({15'h0000, busy}, 16'h0000);
    check({1'b0, ram_addr_counter_y, ram_addr_counter_x}, 16'h0000);
    check({8'h00, scan_data}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h0001_FFFF : $urandom();
      host.send_byte(1'b0, CMD_SET_X);
      host.send_byte(1'b1, v[7:0]);
      settle();
      check({10'h000, ram_addr_counter_x}, {10'h000, v[5:0]});
      host.send_byte(1'b0, CMD_SET_Y);
      host.send_byte(1'b1, v[15:8]);
      host.send_byte(1'b1, {7'h00, v[16]});
      settle();
      check({7'h00, ram_addr_counter_y}, {7'h00, v[16:8]});
      host.send_byte(1'b0, CMD_NOP);
      settle();
      check({1'b0, ram_addr_counter_y, ram_addr_counter_x},
            {1'b0, v[16:8], v[5:0]});
    end
    a = 8'h00;
    foreach (fills[k]) begin
      // Bit 3 stays zero; first-step value drawn at random
      a = fills[k] | {1'($urandom_range(1)), 7'h00};
      run_fill(a);
    end
    host.send_byte(1'b0, CMD_SET_X);
    host.send_byte(1'b1, 8'h30);
    host.send_byte(1'b0, CMD_SET_Y);
    host.send_byte(1'b1, 8'h2B);
    host.send_byte(1'b1, 8'h01);
    host.send_byte(1'b0, CMD_WRITE_BW);
    for (int i = 0; i < 3; i++) begin
      dat[i] = 8'($urandom());
      host.send_byte(1'b1, dat[i]);
    end
    settle();
    check({1'b0, ram_addr_counter_y, ram_addr_counter_x}, 16'h0001);
    host.send_byte(1'b0, CMD_NOP);
    // Differs from the filled byte, so a stray stream write shows
    host.send_byte(1'b1, ~fill_byte(a, 0, 1));
    settle();
    check({1'b0, ram_addr_counter_y, ram_addr_counter_x}, 16'h0001);
    read_at(14998, d);
    check({8'h00, d}, {8'h00, dat[0]});
    read_at(14999, d);
    check({8'h00, d}, {8'h00, dat[1]});
    read_at(0, d);
    check({8'h00, d}, {8'h00, dat[2]});
    read_at(1, d);
    check({8'h00, d}, {8'h00, fill_byte(a, 0, 1)});
    print_verdict();
  end

  // Six fills of 15000 cycles dominate the run time, about 3.65 ms
  initial begin
    #3800000;
    miscompares++;
    print_verdict();
  end
endmodule
